// [core/xtm_core.sv]
`timescale 1ns/100ps
module xtm_core
    import xtm_pkg::*;
(
    input wire logic clk_sys_i, // core clock
    input wire logic rstn_i, // asynchronous reset, active low
    input wire logic instr_valid_i, // an instruction is issued this cycle
    input wire logic [2:0] instr_op_i, // operation code
    input wire logic [7:0] instr_operand_i, // immediate, or file address in low bits
    input wire logic instr_dest_i, // destination bit for the file xor
    input wire logic file_wr_en_i, // side port write into the file
    input wire logic [5:0] file_wr_addr_i, // side port write address
    input wire logic [7:0] file_wr_data_i, // side port write data
    input wire logic [5:0] file_rd_addr_i, // side port read address
    output logic [7:0] file_rd_data_o, // side port read data, one cycle late
    output logic [7:0] accumulator_o, // accumulator contents
    output logic [7:0] timer_mode_o, // timer-0 mode register contents
    output logic zero_flag_o, // zero flag
    output logic digit_carry_flag_o, // digit carry flag
    output logic carry_flag_o, // carry flag
    output logic instr_done_o, // pulse after an executed instruction
    output logic instr_illegal_o // pulse after an unknown operation code
);
    // state
    logic [7:0] accumulator_reg; // working accumulator
    logic [7:0] accumulator_next;
    logic [7:0] tmode_reg; // timer-0 mode register
    logic [7:0] tmode_next;
    logic zero_reg; // status flags
    logic zero_next;
    logic dcarry_reg;
    logic dcarry_next;
    logic carry_reg;
    logic carry_next;
    logic [7:0] file_reg [XTM_FILE_DEPTH]; // data memory in flip-flops
    logic [7:0] rd_data_reg; // registered side port read
    logic done_reg; // completion pulse
    logic illegal_reg; // illegal opcode pulse

    // decoded operation
    // strobes below are mutually exclusive by construction
    wire logic [5:0] file_addr; // file address from operand
    wire logic [7:0] file_rd_val; // addressed file register value
    wire logic op_nop;
    wire logic op_load_acc;
    wire logic op_preset;
    wire logic op_ld_tmode;
    wire logic op_rd_tmode;
    wire logic op_xor_file;
    wire logic op_xor_imm;
    wire logic op_known; // any legal code
    wire logic xor_to_file; // file xor result goes back to the register
    wire logic file_instr_we; // instruction writes the file
    wire logic [7:0] file_instr_data;
    wire logic xor_to_acc; // file xor result goes to the accumulator
    wire logic zero_update; // of the two xors, only the immediate form moves the zero flag
    wire logic flags_preset; // preset loads all three flags
    wire logic [7:0] xor_result; // exclusive-or unit output
    wire logic xor_zero; // exclusive-or unit zero detect

    xtm_alu_if alu_bus ();

    // returns true when a valid instruction carries the given code
    // keeps the valid qualifier in one place so nothing decodes while idle
    function automatic logic xtm_is_op(input logic valid, input logic [2:0] code,
                                       input xtm_op_type want);
        xtm_is_op = valid && (code == want);
    endfunction : xtm_is_op

    // decode: one strobe per operation code, all gated by valid;
    // code 7 matches nothing and so raises only the illegal pulse
    assign op_nop = xtm_is_op(instr_valid_i, instr_op_i, XTM_OP_NOP);
    assign op_load_acc = xtm_is_op(instr_valid_i, instr_op_i, XTM_OP_LOAD_ACC);
    assign op_preset = xtm_is_op(instr_valid_i, instr_op_i, XTM_OP_PRESET_FLAGS);
    assign op_ld_tmode = xtm_is_op(instr_valid_i, instr_op_i,
                                   XTM_OP_LOAD_TIMER_MODE_FROM_ACC);
    assign op_rd_tmode = xtm_is_op(instr_valid_i, instr_op_i,
                                   XTM_OP_READ_TIMER_MODE_TO_ACC);
    assign op_xor_file = xtm_is_op(instr_valid_i, instr_op_i,
                                   XTM_OP_XOR_ACC_WITH_FILE_REG);
    assign op_xor_imm = xtm_is_op(instr_valid_i, instr_op_i,
                                  XTM_OP_XOR_ACC_WITH_IMMEDIATE);
    assign op_known = op_nop | op_load_acc | op_preset | op_ld_tmode | op_rd_tmode
                    | op_xor_file | op_xor_imm;

    // operand selection for the xor unit
    // the file value is read combinationally from the operand address
    assign file_addr = instr_operand_i[5:0];
    assign file_rd_val = file_reg[file_addr];
    assign alu_bus.opnd_a = accumulator_reg;
    assign alu_bus.opnd_b = op_xor_file ? file_rd_val : instr_operand_i;

    // file write back when the destination bit is set
    assign xor_to_file = op_xor_file && (instr_dest_i == XTM_DEST_FILE);
    assign xor_to_acc = op_xor_file && (instr_dest_i == XTM_DEST_ACC);
    assign file_instr_we = xor_to_file;
    assign xor_result = alu_bus.result;
    assign xor_zero = alu_bus.zero;
    assign file_instr_data = xor_result;

    // flag update strobes
    assign flags_preset = op_preset;
    assign zero_update = op_xor_imm;

    // exclusive-or unit, shared by the file and immediate forms;
    // it sees the accumulator as it stood before this edge
    xtm_alu u_alu (
        .alu_bus (alu_bus)
    );

    // accumulator next value
    // one source at most per cycle, the decode strobes are exclusive
    always_comb begin
        accumulator_next = accumulator_reg;
        if (op_load_acc) begin
            accumulator_next = instr_operand_i; // plain load
        end else if (op_rd_tmode) begin
            accumulator_next = tmode_reg;
        end else if (xor_to_acc) begin
            accumulator_next = xor_result;
        end else if (op_xor_imm) begin
            accumulator_next = xor_result;
        end
    end

    // timer mode next value, only the load touches it
    // the timer itself lives elsewhere; only its mode byte is kept here
    always_comb begin
        tmode_next = tmode_reg;
        if (op_ld_tmode) begin
            tmode_next = accumulator_reg;
        end
    end

    // flags: only the preset and the immediate xor change them
    // the file xor and both timer mode moves leave all three alone
    always_comb begin
        zero_next = zero_reg;
        dcarry_next = dcarry_reg;
        carry_next = carry_reg;
        if (flags_preset) begin
            zero_next = instr_operand_i[XTM_PRESET_Z_POS];
            dcarry_next = instr_operand_i[XTM_PRESET_DC_POS];
            carry_next = instr_operand_i[XTM_PRESET_C_POS];
        end else if (zero_update) begin
            zero_next = xor_zero;
        end
    end

    // accumulator and timer mode registers
    // both load every edge; the next-value logic holds them when idle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            accumulator_reg <= XTM_ACC_RST;
            tmode_reg <= XTM_TMODE_RST;
        end else begin
            accumulator_reg <= accumulator_next;
            tmode_reg <= tmode_next;
        end
    end

    // status flag registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            zero_reg <= XTM_FLAG_RST;
            dcarry_reg <= XTM_FLAG_RST;
            carry_reg <= XTM_FLAG_RST;
        end else begin
            zero_reg <= zero_next;
            dcarry_reg <= dcarry_next;
            carry_reg <= carry_next;
        end
    end

    // file storage, the instruction write wins over the side port
    // a side write in the same cycle as a file xor write back is dropped
    // without any indication, so the side port must not overlap the two
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < XTM_FILE_DEPTH; i++) begin
                file_reg[i] <= XTM_FILE_RST;
            end
        end else if (file_instr_we) begin
            file_reg[file_addr] <= file_instr_data;
        end else if (file_wr_en_i) begin
            file_reg[file_wr_addr_i] <= file_wr_data_i;
        end
    end

    // side read port, one cycle of latency
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_reg <= XTM_FILE_RST;
        end else begin
            rd_data_reg <= file_reg[file_rd_addr_i]; // sees writes one edge later
        end
    end

    // completion pulses, each high for one cycle after the op is taken
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            done_reg <= op_known; // legal codes, nop included
            illegal_reg <= instr_valid_i && !op_known; // unknown code, state untouched
        end
    end

    // outputs, all from flip-flops
    // nothing combinational reaches a port, which keeps output timing simple
    assign file_rd_data_o = rd_data_reg;
    assign accumulator_o = accumulator_reg;
    assign timer_mode_o = tmode_reg;
    assign zero_flag_o = zero_reg;
    assign digit_carry_flag_o = dcarry_reg;
    assign carry_flag_o = carry_reg;
    assign instr_done_o = done_reg;
    assign instr_illegal_o = illegal_reg;
endmodule : xtm_core

// [core/xtm_pkg.sv]
package xtm_pkg;
    // data and address widths
    localparam int XTM_DATA_W = 8;
    localparam int XTM_ADDR_W = 6;
    localparam int XTM_FILE_DEPTH = 64;
    localparam int XTM_OP_W = 3;
    // instruction cycles taken by every operation
    localparam int XTM_EXEC_CYCLES = 1;
    // reset values
    localparam logic [7:0] XTM_ACC_RST = 8'h00;
    localparam logic [7:0] XTM_TMODE_RST = 8'h00;
    localparam logic [7:0] XTM_FILE_RST = 8'h00;
    localparam logic XTM_FLAG_RST = 1'b0;
    // field positions in the operand for the flag preset operation
    localparam int XTM_PRESET_C_POS = 0;
    localparam int XTM_PRESET_DC_POS = 1;
    localparam int XTM_PRESET_Z_POS = 2;
    // destination bit values
    localparam logic XTM_DEST_ACC = 1'b0;
    localparam logic XTM_DEST_FILE = 1'b1;
    // operation codes
    typedef enum logic [2:0] {
        XTM_OP_NOP                      = 3'h0,
        XTM_OP_LOAD_ACC                 = 3'h1,
        XTM_OP_PRESET_FLAGS             = 3'h2,
        XTM_OP_LOAD_TIMER_MODE_FROM_ACC = 3'h3,
        XTM_OP_READ_TIMER_MODE_TO_ACC   = 3'h4,
        XTM_OP_XOR_ACC_WITH_FILE_REG    = 3'h5,
        XTM_OP_XOR_ACC_WITH_IMMEDIATE   = 3'h6
    } xtm_op_type;
endpackage : xtm_pkg

// [core/xtm_alu_if.sv]
`timescale 1ns/100ps
interface xtm_alu_if;
    logic [7:0] opnd_a; // first operand, the accumulator
    logic [7:0] opnd_b; // second operand, file register or immediate
    logic [7:0] result; // exclusive-or result
    logic zero; // result is all zero
    modport alu (input opnd_a, input opnd_b, output result, output zero);
    modport core (output opnd_a, output opnd_b, input result, input zero);
endinterface : xtm_alu_if

// [core/xtm_alu.sv]
`timescale 1ns/100ps
module xtm_alu
    import xtm_pkg::*;
(
    xtm_alu_if.alu alu_bus
);
    // purely combinational exclusive-or and zero detect
    assign alu_bus.result = alu_bus.opnd_a ^ alu_bus.opnd_b;
    assign alu_bus.zero = (alu_bus.result == 8'h00);
endmodule : xtm_alu

// [tb/xtm_core_asserts.sv]
`timescale 1ns/100ps
// watches the core ports around the moves and xors
module xtm_core_asserts
    import xtm_pkg::*;
(
    input wire logic clk_sys_i, // core clock
    input wire logic rstn_i, // reset, active low
    input wire logic instr_valid_i,
    input wire logic [2:0] instr_op_i,
    input wire logic instr_dest_i,
    input wire logic [7:0] instr_operand_i,
    input wire logic [7:0] accumulator_o,
    input wire logic [7:0] timer_mode_o,
    input wire logic zero_flag_o,
    input wire logic digit_carry_flag_o,
    input wire logic carry_flag_o,
    input wire logic instr_done_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // all three flags in one vector
    wire logic [2:0] flags = {zero_flag_o, digit_carry_flag_o, carry_flag_o};
    wire logic [2:0] op = instr_op_i;
    chk_tmode_load: assert property (instr_valid_i && op == 3'h3 |=>
        timer_mode_o == $past(accumulator_o) && $stable(accumulator_o) && $stable(flags))
        else $error("timer mode load wrong");
    chk_tmode_read: assert property (instr_valid_i && op == 3'h4 |=>
        accumulator_o == $past(timer_mode_o) && $stable(timer_mode_o) && $stable(flags))
        else $error("timer mode read wrong");
    chk_fxor_keeps: assert property (instr_valid_i && op == 3'h5 |=>
        $stable(flags) && $stable(timer_mode_o) && (!$past(instr_dest_i) || $stable(accumulator_o)))
        else $error("file xor disturbed state");
    chk_ixor_result: assert property (instr_valid_i && op == 3'h6 |=>
        accumulator_o == ($past(accumulator_o) ^ $past(instr_operand_i))
        && zero_flag_o == (accumulator_o == 8'h00) && $stable(flags[1:0]))
        else $error("immediate xor wrong");
    chk_done_pulse: assert property (instr_valid_i && op != 3'h7 |=> instr_done_o)
        else $error("done pulse missing");
endmodule : xtm_core_asserts

bind xtm_core xtm_core_asserts chk (.clk_sys_i, .rstn_i, .instr_valid_i, .instr_op_i,
    .instr_dest_i, .instr_operand_i, .accumulator_o, .timer_mode_o, .zero_flag_o,
    .digit_carry_flag_o, .carry_flag_o, .instr_done_o);

// [tb/tb_xtm_core.sv]
`timescale 1ns/100ps
// drives the core instruction and file ports and judges results
module tb_xtm_core;
    import xtm_pkg::*;
    logic clk_sys_i = 1'h0; // core clock
    logic rstn_i = 1'h0; // reset, active low
    logic instr_valid_i = 1'h0;
    logic instr_dest_i = 1'h0;
    logic file_wr_en_i = 1'h0;
    logic [2:0] instr_op_i = 3'h0;
    logic [7:0] instr_operand_i = 8'h00;
    logic [5:0] file_wr_addr_i = 6'h00;
    logic [5:0] file_rd_addr_i = 6'h00;
    logic [7:0] file_wr_data_i = 8'h00;
    logic [7:0] file_rd_data_o, accumulator_o, timer_mode_o;
    logic zero_flag_o, digit_carry_flag_o, carry_flag_o, instr_done_o, instr_illegal_o;
    int err_count = 0; // mismatches
    int compares = 0; // comparisons made
    int cycles = 0; // hang guard
    // 40 MHz clock
    always #12.5 clk_sys_i = ~clk_sys_i;
    xtm_core uut (.clk_sys_i, .rstn_i, .instr_valid_i, .instr_op_i, .instr_operand_i,
        .instr_dest_i, .file_wr_en_i, .file_wr_addr_i, .file_wr_data_i, .file_rd_addr_i,
        .file_rd_data_o, .accumulator_o, .timer_mode_o, .zero_flag_o, .digit_carry_flag_o,
        .carry_flag_o, .instr_done_o, .instr_illegal_o);
    // flags packed as z, dc, c
    function automatic logic [7:0] flg();
        return {5'h00, zero_flag_o, digit_carry_flag_o, carry_flag_o};
    endfunction : flg
    // compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one instruction over one edge, then its end pulse
    task issue(input logic [2:0] op, input logic [7:0] opnd, input logic dest);
        @(negedge clk_sys_i);
        instr_valid_i = 1'h1;
        instr_op_i = op;
        instr_operand_i = opnd;
        instr_dest_i = dest;
        @(negedge clk_sys_i);
        instr_valid_i = 1'h0;
        check({7'h00, instr_done_o | instr_illegal_o}, 8'h01);
    endtask : issue
    // side port write and registered read
    task fwrite(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        file_wr_en_i = 1'h1;
        file_wr_addr_i = a;
        file_wr_data_i = d;
        @(negedge clk_sys_i);
        file_wr_en_i = 1'h0;
    endtask : fwrite
    task fread(input logic [5:0] a, input logic [7:0] exp);
        file_rd_addr_i = a;
        @(negedge clk_sys_i);
        check(file_rd_data_o, exp);
    endtask : fread
    // accumulator to timer mode and back, flags held
    task t_tmode;
        issue(XTM_OP_LOAD_ACC, 8'hAA, 1'h0);
        issue(XTM_OP_PRESET_FLAGS, 8'h07, 1'h0);
        issue(XTM_OP_LOAD_TIMER_MODE_FROM_ACC, 8'h00, 1'h0);
        check(timer_mode_o, 8'hAA);
        check(accumulator_o, 8'hAA);
        check(flg(), 8'h07);
        issue(XTM_OP_LOAD_ACC, 8'h55, 1'h0);
        issue(XTM_OP_READ_TIMER_MODE_TO_ACC, 8'h00, 1'h0);
        check(accumulator_o, 8'hAA);
        check(timer_mode_o, 8'hAA);
        check(flg(), 8'h07);
        $display("timer mode test finished");
    endtask : t_tmode
    // file xor to register at top address, then to accumulator
    task t_fxor;
        fwrite(6'h3F, 8'hA5);
        issue(XTM_OP_LOAD_ACC, 8'hF0, 1'h0);
        issue(XTM_OP_PRESET_FLAGS, 8'h05, 1'h0);
        issue(XTM_OP_XOR_ACC_WITH_FILE_REG, 8'hFF, 1'h1);
        check(accumulator_o, 8'hF0);
        fread(6'h3F, 8'h55);
        issue(XTM_OP_XOR_ACC_WITH_FILE_REG, 8'h3F, 1'h0);
        check(accumulator_o, 8'hA5);
        check(flg(), 8'h05);
        fread(6'h3F, 8'h55);
        // write back to file collides with a side write, which is lost
        @(negedge clk_sys_i);
        file_wr_en_i = 1'h1;
        file_wr_addr_i = 6'h3F;
        file_wr_data_i = 8'h11;
        instr_valid_i = 1'h1;
        instr_op_i = XTM_OP_XOR_ACC_WITH_FILE_REG;
        instr_operand_i = 8'h3F;
        instr_dest_i = 1'h1;
        @(negedge clk_sys_i);
        file_wr_en_i = 1'h0;
        instr_valid_i = 1'h0;
        check(accumulator_o, 8'hA5);
        fread(6'h3F, 8'hF0);
        $display("file xor test finished");
    endtask : t_fxor
    // immediate xor to zero and back, carries held; unknown op ignored
    task t_ixor;
        issue(XTM_OP_PRESET_FLAGS, 8'h03, 1'h0);
        issue(XTM_OP_XOR_ACC_WITH_IMMEDIATE, 8'hA5, 1'h0);
        check(accumulator_o, 8'h00);
        check(flg(), 8'h07);
        issue(XTM_OP_XOR_ACC_WITH_IMMEDIATE, 8'h5A, 1'h0);
        check(accumulator_o, 8'h5A);
        check(flg(), 8'h03);
        issue(XTM_OP_NOP, 8'hFF, 1'h1);
        check(accumulator_o, 8'h5A);
        check(flg(), 8'h03);
        issue(3'h7, 8'hFF, 1'h0);
        check({7'h00, instr_illegal_o}, 8'h01);
        check({7'h00, instr_done_o}, 8'h00);
        check(accumulator_o, 8'h5A);
        check(flg(), 8'h03);
        $display("immediate xor test finished");
    endtask : t_ixor
    // counts and verdict
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    // cut a hang short
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 500) begin
            err_count++;
            wrap_up;
        end
    end
    // reset for four cycles, then the tests
    initial begin
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'h1;
        t_tmode;
        t_fxor;
        t_ixor;
        wrap_up;
    end
endmodule : tb_xtm_core
